// file: analog_mode_cmd_pkg.sv
/*
 package for the wake / analog-mode command decoder: opcodes, field positions,
 timing constants and the packed carriers shared by the three design modules.
 assumes a 100 MHz system clock.
*/
package analog_mode_cmd_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int CNT_W = 12;

	// wake-up transition and stop fade-out lengths
	localparam int WAKE_TIME_NS = 2000;
	localparam int FADE_TIME_NS = 5000;
	// line output ramp times, with and without pop suppression
	localparam int LINE_UP_TIME_SUPPRESSED_NS = 20000;
	localparam int LINE_DOWN_TIME_SUPPRESSED_NS = 20000;
	localparam int LINE_UP_TIME_PLAIN_NS = 5000;
	localparam int LINE_DOWN_TIME_PLAIN_NS = 5000;

	localparam int WAKE_CYC = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FADE_CYC = (FADE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UP_SUP_CYC = (LINE_UP_TIME_SUPPRESSED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DN_SUP_CYC = (LINE_DOWN_TIME_SUPPRESSED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int UP_PLAIN_CYC = (LINE_UP_TIME_PLAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DN_PLAIN_CYC = (LINE_DOWN_TIME_PLAIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// command encodings
	localparam logic [6:0] WAKE_OPC = 7'h00;
	localparam logic [5:0] ANALOG_MODE_CMD_OPC = 6'h01;
	localparam logic [7:0] SLEEP_BYTE = 8'h20;
	localparam logic [2:0] CMD_BYTES_MAX = 3'h4;

	// field positions
	localparam int DUP_POS = 0;
	localparam int CLASS_POS = 1;
	localparam int HPF_POS = 0;
	localparam int FADE_POS = 7;
	localparam int DAG_HI = 6;
	localparam int DAG_LO = 5;
	localparam int AIG_HI = 4;
	localparam int AIG_LO = 3;
	localparam int AEN_HI = 2;
	localparam int AEN_LO = 1;
	localparam int POP_POS = 0;

	localparam logic [1:0] GAIN_OFF = 2'h0;
	localparam logic [1:0] GAIN_0DB = 2'h2;
	localparam logic [1:0] GAIN_BAD = 2'h3;
	localparam logic [1:0] AMP_OFF = 2'h0;
	localparam logic [1:0] AMP_SPK = 2'h1;
	localparam logic [1:0] AMP_LINE_SPP = 2'h2;
	localparam logic [1:0] AMP_LINE_LINE_OUT_PIN = 2'h3;

	typedef struct packed {
		logic amp_class;
		logic highpass;
		logic stop_fade;
		logic [1:0] dac_gain;
		logic [1:0] ext_gain;
		logic [1:0] amp_en;
		logic pop;
	} analog_cfg_t;

	localparam analog_cfg_t ANALOG_CFG_INIT = '0;

	typedef struct packed {
		logic frame_start;
		logic byte_valid;
		logic [7:0] data;
		logic frame_end;
	} rx_evt_t;

	typedef enum logic [2:0] {
		ST_SLEEP = 3'b000,
		ST_WAKING = 3'b001,
		ST_STANDBY = 3'b010,
		ST_ANA_RAMP = 3'b011,
		ST_SLEEPING = 3'b100
	} dev_state_t;

endpackage

// file: cmd_byte_rx.sv
/*
 serial command byte receiver: synchronises the select, clock and data pins,
 shifts data on rising serial clock edges, msb first, and reports frame start,
 each complete byte and frame end as one-cycle events.
 assumes the serial clock is much slower than clk.
*/
module cmd_byte_rx
	import analog_mode_cmd_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output rx_evt_t evt
);

	typedef struct packed {
		logic [1:0] s_sclk;
		logic [1:0] s_cs_n;
		logic [1:0] s_mosi;
		logic sclk_q;
		logic cs_n_q;
		logic [7:0] shift;
		logic [2:0] bit_cnt;
		rx_evt_t evt;
	} rx_state_t;

	rx_state_t st;
	rx_state_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.s_sclk = {st.s_sclk[0], spi_sclk};
		next_st.s_cs_n = {st.s_cs_n[0], spi_cs_n};
		next_st.s_mosi = {st.s_mosi[0], spi_mosi};
		next_st.sclk_q = st.s_sclk[1];
		next_st.cs_n_q = st.s_cs_n[1];
		next_st.evt = '0;
		next_st.evt.frame_start = st.cs_n_q && !st.s_cs_n[1];
		next_st.evt.frame_end = !st.cs_n_q && st.s_cs_n[1];
		if (next_st.evt.frame_start)
		begin
			next_st.bit_cnt = 3'h0;
		end
		else if (!st.s_cs_n[1] && st.s_sclk[1] && !st.sclk_q)
		begin
			next_st.shift = {st.shift[6:0], st.s_mosi[1]};
			next_st.bit_cnt = st.bit_cnt + 3'h1;
			if (st.bit_cnt == 3'h7)
			begin
				next_st.evt.byte_valid = 1'b1;
				next_st.evt.data = {st.shift[6:0], st.s_mosi[1]};
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
			st.s_cs_n <= 2'h3;
			st.cs_n_q <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign evt = st.evt;

endmodule

// file: line_ramp.sv
/*
 output ramp timer: on start, counts the power-up or power-down time of the
 analog output, long with pop suppression and short without, then pulses done.
 assumes start is a one-cycle pulse and is not repeated while busy.
*/
module line_ramp
	import analog_mode_cmd_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic up,
	input wire logic suppressed,
	output logic busy,
	output logic done
);

	typedef struct packed {
		logic busy;
		logic done;
		logic [CNT_W-1:0] cnt;
	} ramp_state_t;

	ramp_state_t st;
	ramp_state_t next_st;

	function automatic logic [CNT_W-1:0] ramp_len(input logic dir_up, input logic sup);
		int c;
		c = dir_up ? (sup ? UP_SUP_CYC : UP_PLAIN_CYC) : (sup ? DN_SUP_CYC : DN_PLAIN_CYC);
		return CNT_W'(c);
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.done = 1'b0;
		if (start)
		begin
			next_st.busy = 1'b1;
			next_st.cnt = ramp_len(up, suppressed);
		end
		else if (st.busy)
		begin
			if (st.cnt <= CNT_W'(1))
			begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				next_st.cnt = '0;
			end
			else
			begin
				next_st.cnt = st.cnt - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign busy = st.busy;
	assign done = st.done;

endmodule

// file: analog_mode_ctrl.sv
/*
 wake / sleep / analog-mode command decoder with duplicate-entry checking,
 analog output configuration, line ramp sequencing and stop fade-out busy.
 assumes a serial command port with a frame select, playback_active and
 stop_req come from logic on clk.
*/
// How it works
// (RULE1) asleep, only wake command is accepted
// (RULE2) wake command moves to command standby
// (RULE3) host sends sleep command to power down
// (RULE4) duplicate bit set: every byte sent twice
// (RULE5) copies differing: command discarded, not executed
// (RULE6) address once, command bytes twice; the code takes every byte twice, the first byte too
// (RULE7) duplicate mode off after reset
// (RULE8) analog command ignored asleep, transitioning, playing
// (RULE9) sleep powers down with last analog settings
// (RULE10) host zeroes channel volume before analog power-up
// (RULE11) analog settings initialise at reset and sleep
// (RULE12) class bit: 0 AB, 1 D; keep 0
// (RULE13) highpass bit enables 200 Hz filter
// (RULE14) stop-fade bit selects fade-out on stop
// (RULE15) channel busy low during stop fade-out
// (RULE16) dac mix gain off, -6, 0 dB
// (RULE17) input gain off, -6, 0 dB
// (RULE18) host waits command busy high before input
// (RULE19) pop suppression only for line output
// (RULE20) enable pairs select speaker or line path
// (RULE21) line ramp time depends on pop suppression
// (RULE22) wake one byte; analog mode two bytes
module analog_mode_ctrl
	import analog_mode_cmd_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic playback_active,
	input wire logic [3:0] stop_req,
	output logic powered_up,
	output logic dup_entry_mode,
	output logic command_busy_n,
	output logic [3:0] channel_busy_n,
	output analog_cfg_t analog_cfg,
	output logic [1:0] dac_mix_gain,
	output logic [1:0] ext_in_gain,
	output logic pop_suppress,
	output logic speaker_path_on,
	output logic line_spp_on,
	output logic line_line_out_pin_on,
	output logic line_at_sg,
	output logic cmd_discard
);

	typedef struct packed {
		dev_state_t state;
		logic dup_mode;
		logic awake;
		analog_cfg_t cfg;
		logic [3:0][7:0] bytes;
		logic [2:0] cnt;
		logic ovf;
		logic cmd_busy_n;
		logic discard;
		logic [1:0] dac_gain;
		logic [1:0] ext_gain;
		logic pop_sup;
		logic spk_on;
		logic spp_on;
		logic line_out_pin_on;
		logic at_sg;
		logic ramp_start;
		logic ramp_up;
		logic ramp_sup;
		logic [CNT_W-1:0] wake_cnt;
		logic [3:0][CNT_W-1:0] fade_cnt;
		logic [3:0] busy_n;
	} ctrl_state_t;

	ctrl_state_t st;
	ctrl_state_t next_st;
	rx_evt_t rx;
	logic ramp_busy;
	logic ramp_done;

	cmd_byte_rx u_rx (
		.clk(clk),
		.rstn(rstn),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi),
		.evt(rx)
	);

	line_ramp u_ramp (
		.clk(clk),
		.rstn(rstn),
		.start(st.ramp_start),
		.up(st.ramp_up),
		.suppressed(st.ramp_sup),
		.busy(ramp_busy),
		.done(ramp_done)
	);

	// gain takes effect only for class ab speaker output; code 11 acts as 0 dB
	function automatic logic [1:0] eff_gain(input logic [1:0] g, input analog_cfg_t c);
		logic [1:0] r;
		r = (g == GAIN_BAD) ? GAIN_0DB : g;
		if (c.amp_class || c.amp_en != AMP_SPK)
		begin
			r = GAIN_OFF;
		end
		return r;
	endfunction

	function automatic analog_cfg_t decode_cfg(input logic [7:0] b0, input logic [7:0] b1);
		analog_cfg_t c;
		c.amp_class = b0[CLASS_POS];
		c.highpass = b0[HPF_POS];
		c.stop_fade = b1[FADE_POS];
		c.dac_gain = b1[DAG_HI:DAG_LO];
		c.ext_gain = b1[AIG_HI:AIG_LO];
		c.amp_en = b1[AEN_HI:AEN_LO];
		c.pop = b1[POP_POS];
		return c;
	endfunction

	always_comb
	begin
		logic [7:0] first;
		logic [7:0] second;
		logic mism;
		logic bad;
		logic [2:0] lcnt;
		logic idle_ch;
		analog_cfg_t ncfg;
		first = st.bytes[0];
		second = st.dup_mode ? st.bytes[2] : st.bytes[1];
		mism = st.dup_mode && ((st.bytes[0] != st.bytes[1]) ||
			(st.cnt == CMD_BYTES_MAX && st.bytes[2] != st.bytes[3])); // RULE4
		bad = st.ovf || mism || (st.dup_mode && st.cnt[0]);
		lcnt = st.dup_mode ? {1'b0, st.cnt[2:1]} : st.cnt; // RULE6
		idle_ch = &st.busy_n;
		ncfg = decode_cfg(first, second); // RULE22
		next_st = st;
		next_st.discard = 1'b0;
		next_st.ramp_start = 1'b0;

		// frame byte collection
		if (rx.frame_start)
		begin
			next_st.cnt = 3'h0;
			next_st.ovf = 1'b0;
		end
		else if (rx.byte_valid)
		begin
			if (st.cnt == CMD_BYTES_MAX)
			begin
				next_st.ovf = 1'b1;
			end
			else
			begin
				next_st.bytes[st.cnt[1:0]] = rx.data;
				next_st.cnt = st.cnt + 3'h1;
			end
		end

		unique case (st.state)
			ST_SLEEP:
			begin
				// anything but a lone wake byte is dropped silently
				if (rx.frame_end && st.cnt == 3'h1 && !st.ovf &&
					first[7:1] == WAKE_OPC) // RULE1 RULE22
				begin
					next_st.dup_mode = first[DUP_POS]; // RULE4
					next_st.state = ST_WAKING; // RULE2
					next_st.wake_cnt = CNT_W'(WAKE_CYC);
					next_st.cmd_busy_n = 1'b0;
				end
			end
			ST_WAKING:
			begin
				if (st.wake_cnt <= CNT_W'(1))
				begin
					next_st.state = ST_STANDBY; // RULE2
					next_st.cmd_busy_n = 1'b1;
				end
				else
				begin
					next_st.wake_cnt = st.wake_cnt - CNT_W'(1);
				end
			end
			ST_STANDBY:
			begin
				if (rx.frame_end && st.cnt != 3'h0)
				begin
					if (bad)
					begin
						next_st.discard = 1'b1; // RULE5
					end
					else if (lcnt == 3'h1 && first == SLEEP_BYTE && !playback_active && idle_ch)
					begin
						if (st.cfg.amp_en != AMP_OFF)
						begin
							// power down on the settings last applied
							next_st.ramp_start = 1'b1; // RULE9
							next_st.ramp_up = 1'b0;
							next_st.ramp_sup = st.cfg.pop && st.cfg.amp_en[1]; // RULE21
							next_st.state = ST_SLEEPING;
							next_st.cmd_busy_n = 1'b0;
						end
						else
						begin
							next_st.cfg = ANALOG_CFG_INIT; // RULE11
							next_st.dup_mode = 1'b0;
							next_st.state = ST_SLEEP;
						end
					end
					else if (lcnt == 3'h2 && first[7:2] == ANALOG_MODE_CMD_OPC && !playback_active) // RULE8
					begin
						next_st.cfg = ncfg; // RULE12 RULE13 RULE14
						if ((ncfg.amp_en != AMP_OFF) != (st.cfg.amp_en != AMP_OFF))
						begin
							next_st.ramp_start = 1'b1;
							next_st.ramp_up = ncfg.amp_en != AMP_OFF;
							next_st.ramp_sup = ncfg.pop &&
								(ncfg.amp_en[1] || st.cfg.amp_en[1]); // RULE21
							next_st.state = ST_ANA_RAMP;
							next_st.cmd_busy_n = 1'b0; // RULE18
							next_st.at_sg = 1'b0;
						end
					end
				end
			end
			ST_ANA_RAMP:
			begin
				if (ramp_done)
				begin
					next_st.state = ST_STANDBY;
					next_st.cmd_busy_n = 1'b1; // RULE18
					next_st.at_sg = st.ramp_up && st.cfg.amp_en[1]; // RULE21
				end
			end
			ST_SLEEPING:
			begin
				if (ramp_done)
				begin
					next_st.cfg = ANALOG_CFG_INIT; // RULE11
					next_st.dup_mode = 1'b0;
					next_st.state = ST_SLEEP;
					next_st.cmd_busy_n = 1'b1;
					next_st.at_sg = 1'b0;
				end
			end
			default:
			begin
				next_st.state = ST_SLEEP;
				next_st.cmd_busy_n = 1'b1;
			end
		endcase

		// stop fade-out holds the channel busy low
		for (int i = 0; i < 4; i++)
		begin
			if (stop_req[i] && st.cfg.stop_fade) // RULE14
			begin
				next_st.fade_cnt[i] = CNT_W'(FADE_CYC);
			end
			else if (st.fade_cnt[i] != '0)
			begin
				next_st.fade_cnt[i] = st.fade_cnt[i] - CNT_W'(1);
			end
			next_st.busy_n[i] = next_st.fade_cnt[i] == '0; // RULE15
		end

		next_st.dac_gain = eff_gain(next_st.cfg.dac_gain, next_st.cfg); // RULE16
		next_st.ext_gain = eff_gain(next_st.cfg.ext_gain, next_st.cfg); // RULE17
		next_st.pop_sup = next_st.cfg.pop && next_st.cfg.amp_en[1]; // RULE19
		next_st.spk_on = next_st.cfg.amp_en == AMP_SPK; // RULE20
		next_st.spp_on = next_st.cfg.amp_en == AMP_LINE_SPP; // RULE20
		next_st.line_out_pin_on = next_st.cfg.amp_en == AMP_LINE_LINE_OUT_PIN; // RULE20
		next_st.awake = next_st.state != ST_SLEEP; // RULE2
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
			st.state <= ST_SLEEP;
			st.dup_mode <= 1'b0; // RULE7
			st.cfg <= ANALOG_CFG_INIT; // RULE11
			st.cmd_busy_n <= 1'b1;
			st.busy_n <= 4'hF;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign powered_up = st.awake;
	assign dup_entry_mode = st.dup_mode;
	assign command_busy_n = st.cmd_busy_n;
	assign channel_busy_n = st.busy_n;
	assign analog_cfg = st.cfg;
	assign dac_mix_gain = st.dac_gain;
	assign ext_in_gain = st.ext_gain;
	assign pop_suppress = st.pop_sup;
	assign speaker_path_on = st.spk_on;
	assign line_spp_on = st.spp_on;
	assign line_line_out_pin_on = st.line_out_pin_on;
	assign line_at_sg = st.at_sg;
	assign cmd_discard = st.discard;

	localparam int WAKE_BOUND = WAKE_CYC + 1;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sleep_only_wake_a: assert property ( // RULE1
		st.state == ST_SLEEP |=> st.state inside {ST_SLEEP, ST_WAKING})
		else $error("left power-down other than by wake");

	wake_to_standby_a: assert property ( // RULE2
		st.state == ST_SLEEP && next_st.state == ST_WAKING |=>
		##[1:WAKE_BOUND] st.state == ST_STANDBY)
		else $error("wake did not reach standby in time");

	dup_off_asleep_a: assert property ( // RULE7
		st.state == ST_SLEEP |-> !st.dup_mode)
		else $error("duplicate mode set while asleep");

	discard_keeps_cfg_a: assert property ( // RULE5
		st.discard |-> st.cfg == $past(st.cfg) && st.state == ST_STANDBY)
		else $error("discarded command changed settings");

	analog_mode_cmd_ignored_a: assert property ( // RULE8
		rx.frame_end && (playback_active || st.state inside {ST_SLEEP, ST_WAKING, ST_ANA_RAMP})
		|=> st.cfg == $past(st.cfg))
		else $error("analog command taken while not allowed");

	init_when_asleep_a: assert property ( // RULE11
		st.state == ST_SLEEP |-> st.cfg == ANALOG_CFG_INIT)
		else $error("analog settings not initial while asleep");

	fade_busy_low_a: assert property ( // RULE15
		stop_req[0] && st.cfg.stop_fade |=> !channel_busy_n[0] [*8])
		else $error("channel busy not low during fade-out");

	gain_gate_a: assert property ( // RULE16
		(st.cfg.amp_class || st.cfg.amp_en != AMP_SPK) |-> dac_mix_gain == GAIN_OFF &&
		ext_in_gain == GAIN_OFF)
		else $error("gain active outside class ab speaker mode");
	busy_in_ramp_a: assert property ( // RULE18
		(st.state == ST_ANA_RAMP |-> !command_busy_n &&
		(ramp_busy || ramp_done || st.ramp_start)) and
		(st.state == ST_ANA_RAMP && ramp_done |=> command_busy_n))
		else $error("command busy wrong around analog ramp");
	pop_line_only_a: assert property ( // RULE19
		!st.cfg.amp_en[1] |-> !pop_suppress)
		else $error("pop suppression outside line output");

	wake_seen_c: cover property (st.state == ST_WAKING ##1 st.state == ST_STANDBY);
	discard_seen_c: cover property (st.discard && st.dup_mode);
	line_up_c: cover property ($rose(line_at_sg));
	sleep_ramp_c: cover property (st.state == ST_SLEEPING && ramp_done ##1 st.state == ST_SLEEP);

endmodule

// file: spi_host.sv
/*
 host side of the serial command port: sends one frame of bytes, msb first,
 serial clock idle low and still outside frames.
 assumes the caller doubles bytes in duplicate mode; each frame ends with a 200 ns gap.
*/
module spi_host
(
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_mosi
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// one frame per command; class bit and sleep kept by caller, 200 ns gap after the frame kept here
	task automatic send(input logic [7:0] q[$]);
		spi_cs_n = 1'b0;
		#100;
		foreach (q[i])
		begin
			for (int k = 7; k >= 0; k--)
			begin
				spi_mosi = q[i][k];
				#62.5 spi_sclk = 1'b1;
				#62.5 spi_sclk = 1'b0;
			end
		end
		#100 spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
		#200;
	endtask
endmodule

// file: analog_mode_ctrl_bench.sv
/*
 self-checking bench for the wake / analog-mode command decoder.
 assumes the host model sends frames and settles about 20 clk after each.
*/
module analog_mode_ctrl_bench
	import analog_mode_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk, rstn, playback_active, powered_up, dup_entry_mode, command_busy_n;
	logic pop_suppress, speaker_path_on, line_spp_on, line_line_out_pin_on, line_at_sg, cmd_discard;
	logic [3:0] stop_req;
	logic [3:0] channel_busy_n;
	logic [1:0] dac_mix_gain, ext_in_gain;
	analog_cfg_t analog_cfg;
	wire logic spi_sclk, spi_cs_n, spi_mosi;
	int miscompares, checks_done, cyc, discards, lowcnt, lastlow, mpow, mdup, n0;
	logic [9:0] mcfg, c;
	logic [31:0] r;

	spi_host u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

	analog_mode_ctrl u_dut (.clk(clk), .rstn(rstn), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .playback_active(playback_active), .stop_req(stop_req),
		.powered_up(powered_up), .dup_entry_mode(dup_entry_mode),
		.command_busy_n(command_busy_n), .channel_busy_n(channel_busy_n),
		.analog_cfg(analog_cfg), .dac_mix_gain(dac_mix_gain), .ext_in_gain(ext_in_gain),
		.pop_suppress(pop_suppress), .speaker_path_on(speaker_path_on),
		.line_spp_on(line_spp_on), .line_line_out_pin_on(line_line_out_pin_on), .line_at_sg(line_at_sg),
		.cmd_discard(cmd_discard));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cmd_discard === 1'b1)
			discards++;
		if (command_busy_n === 1'b0)
			lowcnt++;
		else if (lowcnt != 0)
		begin
			lastlow = lowcnt;
			lowcnt = 0;
		end
		if (cyc == 60000)
		begin
			miscompares++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic near(input string what, input int got, input int exp);
		check(what, (got >= exp - 2 && got <= exp + 4), 1);
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic frame(input logic [7:0] q[$]);
		logic [7:0] s[$];
		foreach (q[i])
		begin
			s.push_back(q[i]);
			if (mdup != 0)
				s.push_back(q[i]);
		end
		u_host.send(s);
	endtask

	task automatic wait_ready();
		int n;
		n = 0;
		while (command_busy_n !== 1'b1 && n < 3000)
		begin
			tick();
			n++;
		end
		tick();
		check("ready", n < 3000, 1);
	endtask

	task automatic expect_cfg();
		logic [1:0] a, dg, eg;
		a = mcfg[2:1];
		dg = (mcfg[6:5] == 2'h3) ? 2'h2 : mcfg[6:5];
		eg = (mcfg[4:3] == 2'h3) ? 2'h2 : mcfg[4:3];
		check("cfg", analog_cfg, mcfg);
		check("dac gain", dac_mix_gain, (!mcfg[9] && a == 2'h1) ? dg : 2'h0);
		check("ext gain", ext_in_gain, (!mcfg[9] && a == 2'h1) ? eg : 2'h0);
		check("pop", pop_suppress, mcfg[0] & a[1]);
		check("paths", {speaker_path_on, line_spp_on, line_line_out_pin_on},
			{a == 2'h1, a == 2'h2, a == 2'h3});
		check("power", {powered_up, dup_entry_mode}, {mpow[0], mdup[0]});
	endtask

	task automatic analog_mode_cmd(input logic [9:0] v, input int applies);
		logic [9:0] old;
		old = mcfg;
		frame('{{ANALOG_MODE_CMD_OPC, v[9:8]}, v[7:0]});
		if (applies != 0)
			mcfg = v;
		expect_cfg();
		wait_ready();
		if (applies != 0 && old[2:1] == 2'h0 && v[2:1] != 2'h0)
		begin
			near("up ramp", lastlow, (v[2] && v[0]) ? UP_SUP_CYC : UP_PLAIN_CYC);
			check("at sg", line_at_sg, v[2]);
		end
	endtask

	task automatic sleep(input int applies);
		logic [9:0] old;
		old = mcfg;
		frame('{SLEEP_BYTE});
		wait_ready();
		if (applies != 0)
		begin
			if (old[2:1] != 2'h0)
				near("down ramp", lastlow, (old[2] && old[0]) ? DN_SUP_CYC : DN_PLAIN_CYC);
			mpow = 0;
			mdup = 0;
			mcfg = '0;
		end
		expect_cfg();
	endtask

	task automatic wake(input logic d);
		frame('{{WAKE_OPC, d}});
		wait_ready();
		near("wake time", lastlow, WAKE_CYC);
		mpow = 1;
		mdup = d;
		expect_cfg();
	endtask

	task automatic stop_ch(input int i, input int fade);
		int n;
		tick();
		stop_req[i] = 1'b1;
		tick();
		stop_req = 4'h0;
		n = 0;
		while (channel_busy_n[i] === 1'b0 && n < 1000)
		begin
			tick();
			n++;
		end
		if (fade != 0)
			near("fade", n, FADE_CYC);
		else
			check("no fade", n, 0);
		check("busy high", channel_busy_n, 4'hF);
	endtask

	initial
	begin
		rstn = 1'b0;
		playback_active = 1'b0;
		stop_req = 4'h0;
		{mpow, mdup, mcfg} = '0;
		void'($urandom(32'hE3F07821));
		repeat (8) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (4) tick();
		expect_cfg();
		check("busy", {command_busy_n, channel_busy_n}, 5'h1F);
		analog_mode_cmd(10'h0F7, 0);
		sleep(0);
		wake(1'b0);
		for (int a = 1; a < 4; a++)
		begin
			r = $urandom;
			c = {1'b0, r[0], r[1], r[3:2] == 2'h3 ? 2'h1 : r[3:2], r[5:4] == 2'h3 ? 2'h2 : r[5:4],
				a[1:0], r[6]};
			analog_mode_cmd(c, 1);
			analog_mode_cmd({c[9:3], 2'h0, c[0]}, 1);
		end
		tick();
		playback_active = 1'b1;
		analog_mode_cmd(10'h007, 0);
		sleep(0);
		tick();
		playback_active = 1'b0;
		sleep(1);
		wake(1'b0);
		analog_mode_cmd(10'h080, 1);
		for (int i = 0; i < 4; i++)
			stop_ch(i, 1);
		analog_mode_cmd(10'h000, 1);
		stop_ch(2, 0);
		frame('{8'hAF, 8'h00});
		expect_cfg();
		analog_mode_cmd(10'h007, 1);
		sleep(1);
		wake(1'b1);
		analog_mode_cmd(10'h053, 1);
		n0 = discards;
		u_host.send('{8'h05, 8'h04, 8'h00, 8'h00});
		check("discard", discards, n0 + 1);
		expect_cfg();
		u_host.send('{8'h04, 8'h04, 8'h00});
		check("discard odd", discards, n0 + 2);
		expect_cfg();
		sleep(1);
		end_sim();
	end
endmodule
